// [src/qcsi_pkg.sv]
package qcsi_pkg;
  // ==========================================================================
  // Channel counts and widths
  // ==========================================================================
  localparam int unsigned NUM_ENC    = 4;            // Encoder channels
  localparam int unsigned POS_W      = 24;           // Position accumulator width
  localparam int unsigned DAC_W      = 16;           // Motor and auxiliary DAC code width
  localparam int unsigned NUM_MOT    = 2;            // Motor effort DAC channels
  localparam int unsigned NUM_AUX    = 2;            // Auxiliary DAC channels
  localparam int unsigned SEL_W      = 2;            // DAC select field width
  localparam int unsigned MULT_W     = 16;           // Sample period multiplier width

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [POS_W-1:0] POS_RST  = 24'h00_0000;  // Counters clear at reset
  localparam logic [DAC_W-1:0] DAC_RST  = 16'h0000;     // Mid scale, zero volts
  localparam logic [MULT_W-1:0] MULT_RST = 16'h0001;    // Fastest servo rate

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 10000;      // 10 ns clock period
  localparam int unsigned TICK_PERIOD_PS = 884000000; // 0.000884 s base tick
  // Longest time, so round down to whole cycles
  localparam int unsigned TICK_CYCLES   = TICK_PERIOD_PS / CLK_PERIOD_PS;

  // ==========================================================================
  // Quadrature step encoding
  // ==========================================================================
  localparam logic [1:0] STEP_NONE = 2'h0;            // No movement
  localparam logic [1:0] STEP_UP   = 2'h1;            // One count forward
  localparam logic [1:0] STEP_DN   = 2'h2;            // One count backward
  localparam logic [1:0] STEP_ERR  = 2'h3;            // Both channels moved at once
endpackage

// [src/qcsi_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module qcsi_decoder #(
  parameter int unsigned POS_W = qcsi_pkg::POS_W
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             chan_a_in,
  input  wire logic             chan_b_in,
  output logic [POS_W-1:0]      pos_ff,
  output logic                  phase_err_ff
);
  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [1:0] a_sync_ff;                         // Stage 0 metastable, stage 1 clean
  logic [1:0] b_sync_ff;
  logic       a_prev_ff;                         // Last clean level of A
  logic       b_prev_ff;                         // Last clean level of B
  logic [1:0] warm_ff;                           // Enabled cycles since reset, saturating

  // Edges are ignored until both sync stages and the last-level flops hold
  // pin data; otherwise a pin resting high at reset would fake one count
  localparam logic [1:0] WARM_DONE = 2'h3;
  wire logic [1:0] nxt_warm = (warm_ff == WARM_DONE) ? warm_ff : 2'(warm_ff + 2'h1);
  wire logic       live     = (warm_ff == WARM_DONE);

  // Two flops per pin; only stage 1 is read onward
  always_ff @(posedge mclk) begin
    if (rst) begin
      a_sync_ff <= 2'h0;
      b_sync_ff <= 2'h0;
      a_prev_ff <= 1'b0;
      b_prev_ff <= 1'b0;
      warm_ff   <= 2'h0;
    end else if (ce) begin
      a_sync_ff <= {a_sync_ff[0], chan_a_in};
      b_sync_ff <= {b_sync_ff[0], chan_b_in};
      a_prev_ff <= a_sync_ff[1];
      b_prev_ff <= b_sync_ff[1];
      warm_ff   <= nxt_warm;
    end
  end

  // ==========================================================================
  // Step decode
  // ==========================================================================
  wire logic a_now = a_sync_ff[1];
  wire logic b_now = b_sync_ff[1];
  wire logic a_edge = live & (a_now ^ a_prev_ff);  // Rising or falling on A
  wire logic b_edge = live & (b_now ^ b_prev_ff);  // Rising or falling on B
  // A leading B counts up; B leading A counts down
  wire logic fwd = a_edge ? (a_now ^ b_now) : ~(a_now ^ b_now);
  // Every lone edge of either channel is one step, giving 4x resolution; edges on both at once count nothing
  wire logic [1:0] step =
    (a_edge & b_edge) ? qcsi_pkg::STEP_ERR :
    (a_edge | b_edge) ? (fwd ? qcsi_pkg::STEP_UP : qcsi_pkg::STEP_DN) :
                        qcsi_pkg::STEP_NONE;
  // Counter wraps naturally at 2**24 in both directions
  wire logic [POS_W-1:0] nxt_pos =
    (step == qcsi_pkg::STEP_UP) ? POS_W'(pos_ff + 1'b1) :
    (step == qcsi_pkg::STEP_DN) ? POS_W'(pos_ff - 1'b1) : pos_ff;

  // ==========================================================================
  // Position accumulator
  // ==========================================================================
  // Accumulates continuously; software never clears it, only samples it
  always_ff @(posedge mclk) begin
    if (rst) begin
      pos_ff       <= qcsi_pkg::POS_RST;
      phase_err_ff <= 1'b0;
    end else if (ce) begin
      pos_ff <= nxt_pos;
      // Sticky: a double edge means encoder outran the sampler
      if (step == qcsi_pkg::STEP_ERR) begin
        phase_err_ff <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_up_count: assert property (@(posedge mclk) disable iff (rst)
    (ce && step == qcsi_pkg::STEP_UP) |=> pos_ff == POS_W'($past(pos_ff) + 1'b1))
    else $error("up step did not add one");
  a_dn_count: assert property (@(posedge mclk) disable iff (rst)
    (ce && step == qcsi_pkg::STEP_DN) |=> pos_ff == POS_W'($past(pos_ff) - 1'b1))
    else $error("down step did not subtract one");
  a_hold_idle: assert property (@(posedge mclk) disable iff (rst)
    (ce && !a_edge && !b_edge) |=> $stable(pos_ff))
    else $error("counter moved without an edge");
  a_single_edge: assert property (@(posedge mclk) disable iff (rst)
    (ce && (a_edge ^ b_edge)) |-> (step == qcsi_pkg::STEP_UP || step == qcsi_pkg::STEP_DN))
    else $error("single edge not counted");
endmodule
`default_nettype wire

// [src/qcsi_top.sv]
// Summary of operation
// - Channel phase order sets count direction
// - Count every edge of both channels; edges on both at once count nothing
// - Accumulate counts continuously in 24-bit counters
// - Four independent decoder and counter channels
// - Periodic tick, sample period integer multiple
// - Tick interrupt lets servo preempt background
// - 16-bit motor effort code per sample
// - Two optional signed 16-bit auxiliary DACs
`timescale 1ns/1ps
`default_nettype none
module qcsi_top #(
  parameter int unsigned NUM_ENC     = qcsi_pkg::NUM_ENC,
  parameter int unsigned POS_W       = qcsi_pkg::POS_W,
  parameter int unsigned DAC_W       = qcsi_pkg::DAC_W,
  parameter int unsigned TICK_CYCLES = qcsi_pkg::TICK_CYCLES,
  parameter bit          AUX_EN      = 1'b1
) (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic [NUM_ENC-1:0]            enc_a,
  input  wire logic [NUM_ENC-1:0]            enc_b,
  input  wire logic [qcsi_pkg::MULT_W-1:0]   sample_mult,
  input  wire logic                          dac_wr,
  input  wire logic [qcsi_pkg::SEL_W-1:0]    dac_sel,
  input  wire logic [DAC_W-1:0]              dac_code,
  input  wire logic                          tick_ack,
  output logic [NUM_ENC*POS_W-1:0]           pos_ff,
  output logic [NUM_ENC-1:0]                 phase_err_ff,
  output logic                               servo_irq_ff,
  output logic                               base_tick_ff,
  output logic [qcsi_pkg::NUM_MOT*DAC_W-1:0] motor_dac_ff,
  output logic [qcsi_pkg::NUM_AUX*DAC_W-1:0] aux_dac_ff,
  output logic                               dac_load_ff
);
  // ==========================================================================
  // Encoder channels
  // ==========================================================================
  // One decoder per encoder; each counts on its own with no shared state
  for (genvar g = 0; g < NUM_ENC; g++) begin : g_enc
    qcsi_decoder #(.POS_W(POS_W)) u_dec (
      .mclk        (mclk),
      .rst         (rst),
      .ce          (ce),
      .chan_a_in   (enc_a[g]),
      .chan_b_in   (enc_b[g]),
      .pos_ff      (pos_ff[g*POS_W +: POS_W]),
      .phase_err_ff(phase_err_ff[g])
    );
  end

  // ==========================================================================
  // Servo tick timer
  // ==========================================================================
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  logic [TW-1:0]               tick_cnt_ff;      // Cycles inside one base tick
  logic [qcsi_pkg::MULT_W-1:0] mult_cnt_ff;      // Base ticks inside one sample
  logic [qcsi_pkg::MULT_W-1:0] mult_ff;          // Multiplier latched per sample

  wire logic tick_end   = (tick_cnt_ff == TICK_LAST);
  // Zero multiplier is treated as one so the servo never stalls
  wire logic [qcsi_pkg::MULT_W-1:0] mult_safe =
    (sample_mult == '0) ? qcsi_pkg::MULT_RST : sample_mult;
  wire logic sample_end = tick_end && (mult_cnt_ff == mult_ff - 1'b1);
  wire logic [TW-1:0] nxt_tick_cnt = tick_end ? '0 : TW'(tick_cnt_ff + 1'b1);
  wire logic [qcsi_pkg::MULT_W-1:0] nxt_mult_cnt =
    sample_end ? '0 : (tick_end ? qcsi_pkg::MULT_W'(mult_cnt_ff + 1'b1) : mult_cnt_ff);

  // Base tick counter plus multiplier; new multiplier applies at next sample
  // so a period change never produces a short runt sample
  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_cnt_ff  <= '0;
      mult_cnt_ff  <= '0;
      mult_ff      <= qcsi_pkg::MULT_RST;
      base_tick_ff <= 1'b0;
    end else if (ce) begin
      tick_cnt_ff  <= nxt_tick_cnt;
      mult_cnt_ff  <= nxt_mult_cnt;
      base_tick_ff <= tick_end;
      if (sample_end) begin
        mult_ff <= mult_safe;
      end
    end
  end

  // ==========================================================================
  // Interrupt request
  // ==========================================================================
  // Level request held until acknowledged; a new tick beats an ack
  always_ff @(posedge mclk) begin
    if (rst) begin
      servo_irq_ff <= 1'b0;
    end else if (ce) begin
      if (sample_end) begin
        servo_irq_ff <= 1'b1;
      end else if (tick_ack) begin
        servo_irq_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // DAC code holding registers
  // ==========================================================================
  // Select 0,1: motor effort; 2,3: auxiliary (only when option fitted)
  wire logic       sel_aux  = dac_sel[qcsi_pkg::SEL_W-1];
  wire logic       sel_idx  = dac_sel[0];
  wire logic       wr_mot   = dac_wr && !sel_aux;
  wire logic       wr_aux   = dac_wr && sel_aux && AUX_EN;

  // Codes are two's complement; full scale 16'h7FFF maps to +10 V
  always_ff @(posedge mclk) begin
    if (rst) begin
      motor_dac_ff <= '0;
      aux_dac_ff   <= '0;
      dac_load_ff  <= 1'b0;
    end else if (ce) begin
      dac_load_ff <= wr_mot || wr_aux;
      if (wr_mot) begin
        motor_dac_ff[sel_idx*DAC_W +: DAC_W] <= dac_code;
      end
      if (wr_aux) begin
        aux_dac_ff[sel_idx*DAC_W +: DAC_W] <= dac_code;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_sample;
    ce && sample_end;
  endsequence
  a_irq_raise: assert property (@(posedge mclk) disable iff (rst)
    s_sample |=> servo_irq_ff)
    else $error("servo request not raised");
  a_tick_gap: assert property (@(posedge mclk) disable iff (rst)
    (ce && tick_end) |=> (tick_cnt_ff == '0))
    else $error("base tick counter did not restart");
  a_mot_write: assert property (@(posedge mclk) disable iff (rst)
    (ce && wr_mot) |=> motor_dac_ff[$past(sel_idx)*DAC_W +: DAC_W] == $past(dac_code))
    else $error("motor code not stored");
  a_aux_write: assert property (@(posedge mclk) disable iff (rst)
    (ce && wr_aux) |=> aux_dac_ff[$past(sel_idx)*DAC_W +: DAC_W] == $past(dac_code))
    else $error("auxiliary code not stored");
  a_aux_absent: assert property (@(posedge mclk) disable iff (rst)
    !AUX_EN |-> aux_dac_ff == '0)
    else $error("auxiliary written without option");

  // ==========================================================================
  // Servo timer checks
  // ==========================================================================
  // Base tick end on an enabled cycle; the timer only moves when enabled
  sequence s_tick_end;
    ce && tick_end;
  endsequence
  // Counter climbs by one between base tick ends
  a_tick_step: assert property (@(posedge mclk) disable iff (rst)
    (ce && !tick_end) |=> tick_cnt_ff == TW'($past(tick_cnt_ff) + 1'b1))
    else $error("base tick counter skipped a cycle");
  // Every base tick end shows as a pulse on the next cycle
  a_tick_flag: assert property (@(posedge mclk) disable iff (rst)
    s_tick_end |=> base_tick_ff)
    else $error("base tick pulse missing");
  // Pulse stands one cycle; needs a base tick longer than one cycle
  a_tick_pulse: assert property (@(posedge mclk) disable iff (rst)
    (ce && base_tick_ff) |=> !base_tick_ff)
    else $error("base tick pulse stood too long");
  // New multiplier is taken only at a sample boundary
  a_mult_latch: assert property (@(posedge mclk) disable iff (rst)
    s_sample |=> mult_ff == $past(mult_safe))
    else $error("sample multiplier not latched");
  // Clock enable low freezes the whole timer
  a_tick_freeze: assert property (@(posedge mclk) disable iff (rst)
    !ce |=> ($stable(tick_cnt_ff) && $stable(mult_cnt_ff) && $stable(base_tick_ff)))
    else $error("servo timer moved while frozen");

  // ==========================================================================
  // Request checks
  // ==========================================================================
  // Acknowledge with no new sample in the same cycle
  sequence s_ack;
    ce && tick_ack && !sample_end;
  endsequence
  a_irq_clear: assert property (@(posedge mclk) disable iff (rst)
    s_ack |=> !servo_irq_ff)
    else $error("servo request not cleared");
  // A raised request stands until acknowledged
  a_irq_hold: assert property (@(posedge mclk) disable iff (rst)
    (servo_irq_ff && !(ce && tick_ack)) |=> servo_irq_ff)
    else $error("servo request dropped without ack");
  // Only a sample end raises the request
  a_irq_source: assert property (@(posedge mclk) disable iff (rst)
    (!servo_irq_ff && !(ce && sample_end)) |=> !servo_irq_ff)
    else $error("servo request raised off a sample");

  // ==========================================================================
  // DAC checks
  // ==========================================================================
  // Any accepted write, motor or auxiliary
  sequence s_code_wr;
    ce && (wr_mot || wr_aux);
  endsequence
  a_load_set: assert property (@(posedge mclk) disable iff (rst)
    s_code_wr |=> dac_load_ff)
    else $error("load pulse missing after write");
  // Load pulse only follows an accepted write
  a_load_pulse: assert property (@(posedge mclk) disable iff (rst)
    (ce && !wr_mot && !wr_aux) |=> !dac_load_ff)
    else $error("load pulse without write");
  // Held codes do not move while frozen
  a_dac_freeze: assert property (@(posedge mclk) disable iff (rst)
    !ce |=> ($stable(motor_dac_ff) && $stable(aux_dac_ff) && $stable(dac_load_ff)))
    else $error("DAC codes moved while frozen");
endmodule
`default_nettype wire

// [test/qcsi_enc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Encoder model: four shafts, each a 2-bit phase walked in Gray order
// ==========================================================================
module qcsi_enc_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [3:0] step,
  input  wire logic [3:0] dir_up,
  output logic      [3:0] enc_a,
  output logic      [3:0] enc_b
);
  logic [1:0] phase_ff [4];  // Shaft phase, one quarter line per step

  // One step moves one pin only, so the decoder never sees both change
  always_ff @(posedge mclk) begin
    for (int g = 0; g < 4; g++) begin
      if (rst) begin
        phase_ff[g] <= 2'h0;
      end else if (step[g]) begin
        phase_ff[g] <= dir_up[g] ? phase_ff[g] + 2'h1 : phase_ff[g] - 2'h1;
      end
    end
  end

  // Walking up, A rises while B is low
  for (genvar g = 0; g < 4; g++) begin : g_pin
    assign enc_a[g] = phase_ff[g][0] ^ phase_ff[g][1];
    assign enc_b[g] = phase_ff[g][1];
  end
endmodule
`default_nettype wire

// [test/quadrature_counter_servo_if_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bench: random shaft moves, DAC writes and servo tick pacing
// ==========================================================================
module quadrature_counter_servo_if_tb_top;
  localparam int TICK = 20;  // Short base tick keeps the run brief
  localparam int MULT = 3;   // Servo period in base ticks

  logic        mclk;
  logic        rst;
  logic        ce;
  logic [3:0]  step;
  logic [3:0]  dir_up;
  logic [3:0]  enc_a;
  logic [3:0]  enc_b;
  logic [15:0] sample_mult;
  logic        dac_wr;
  logic [1:0]  dac_sel;
  logic [15:0] dac_code;
  logic        tick_ack;
  logic [95:0] pos_ff;
  logic [3:0]  phase_err_ff;
  logic        servo_irq_ff;
  logic        base_tick_ff;
  logic [31:0] motor_dac_ff;
  logic [31:0] aux_dac_ff;
  logic        dac_load_ff;
  int          miscompares = 0;
  int          n_compared = 0;
  integer      seed = 32'hf795_e06e;
  int          exp_pos [4] = '{default: 0};  // Reference counts per shaft
  int          exp_dac [4] = '{default: 0};  // Reference codes, motor then aux
  int          n;

  qcsi_enc_model enc_u (.mclk(mclk), .rst(rst), .step(step), .dir_up(dir_up), .enc_a(enc_a), .enc_b(enc_b));

  qcsi_top #(.TICK_CYCLES(TICK)) dut_u (
    .mclk(mclk), .rst(rst), .ce(ce), .enc_a(enc_a), .enc_b(enc_b), .sample_mult(sample_mult),
    .dac_wr(dac_wr), .dac_sel(dac_sel), .dac_code(dac_code), .tick_ack(tick_ack), .pos_ff(pos_ff),
    .phase_err_ff(phase_err_ff), .servo_irq_ff(servo_irq_ff), .base_tick_ff(base_tick_ff),
    .motor_dac_ff(motor_dac_ff), .aux_dac_ff(aux_dac_ff), .dac_load_ff(dac_load_ff));

  // 100 MHz clock
  always #5 mclk = ~mclk;

  task automatic results;
    $display("Compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Every counter and every code is checked, so cross-talk shows up too
  task automatic chk_all;
    for (int g = 0; g < 4; g++) begin
      chk("pos", exp_pos[g] & 32'h00ff_ffff, {8'h00, pos_ff[g*24+:24]});
      chk("dac", exp_dac[g], {16'h0000, g < 2 ? motor_dac_ff[g*16+:16] : aux_dac_ff[(g-2)*16+:16]});
    end
    chk("err", 0, phase_err_ff);
  endtask

  // One quarter line on shaft g; settle past the input synchroniser
  task automatic move(input int g, input bit up);
    @(posedge mclk);
    step <= 4'h1 << g;
    dir_up <= {4{up}};
    @(posedge mclk);
    step <= 4'h0;
    exp_pos[g] += up ? 1 : -1;
    repeat (5) @(posedge mclk);
    #1 chk_all();
  endtask

  task automatic dac_put(input int sel, input logic [15:0] code);
    @(posedge mclk);
    dac_wr <= 1'b1;
    dac_sel <= sel[1:0];
    dac_code <= code;
    @(posedge mclk);
    dac_wr <= 1'b0;
    exp_dac[sel] = code;
    #1 chk_all();
    chk("load", 1, dac_load_ff);
    @(posedge mclk);
    #1 chk("load", 0, dac_load_ff);
  endtask

  // Bounded wait for the servo request; a hang ends the run as a failure
  task automatic wait_irq(output int cnt);
    cnt = 0;
    while (servo_irq_ff !== 1'b1) begin
      @(posedge mclk);
      #1 cnt++;
      if (cnt > 400) begin
        miscompares++;
        results();
      end
    end
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    step = 4'h0;
    dir_up = 4'h0;
    sample_mult = MULT[15:0];
    dac_wr = 1'b0;
    dac_sel = 2'h0;
    dac_code = 16'h0000;
    tick_ack = 1'b0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk_all();
    chk("irq", 0, servo_irq_ff);
    move(0, 1'b0);
    move(0, 1'b1);
    for (int k = 0; k < 120; k++) begin
      move($random(seed) & 3, $random(seed) & 1);
    end
    // Both ends of the signed range, then random codes, on every select
    for (int k = 0; k < 12; k++) begin
      dac_put(k % 4, k < 4 ? 16'h8000 : (k < 8 ? 16'h7fff : 16'($random(seed))));
    end
    // Clear any request left from the moves, so the first wait sees a fresh rise
    @(posedge mclk);
    tick_ack <= 1'b1;
    @(posedge mclk);
    tick_ack <= 1'b0;
    #1;
    // Processor reads the counters at each servo request, then acknowledges
    for (int k = 0; k < 5; k++) begin
      wait_irq(n);
      chk("tick", 1, base_tick_ff);
      if (k == 2 || k == 4) begin
        chk("period", (k == 2 ? MULT : 1) * TICK - 2, n);
      end
      chk_all();
      @(posedge mclk);
      tick_ack <= 1'b1;
      @(posedge mclk);
      tick_ack <= 1'b0;
      #1 chk("irq", 0, servo_irq_ff);
      // Zero asks for the fastest rate; it takes effect after the next sample
      if (k == 2) begin
        sample_mult <= 16'h0000;
      end
      // Auxiliary codes only in the slack after the servo work
      if (k % 2 == 0) begin
        dac_put(2 + k / 2 % 2, 16'($random(seed)));
      end
    end
    // Clock enable low: a pin moves but nothing counts until it returns
    @(posedge mclk);
    ce <= 1'b0;
    step <= 4'h4;
    dir_up <= 4'hf;
    @(posedge mclk);
    step <= 4'h0;
    repeat (5) @(posedge mclk);
    #1 chk_all();
    chk("irq", 0, servo_irq_ff);
    chk("tick", 0, base_tick_ff);
    @(posedge mclk);
    ce <= 1'b1;
    exp_pos[2] += 1;
    repeat (5) @(posedge mclk);
    #1 chk_all();
    // Second reset in mid run: every counter and code returns to zero
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    exp_pos = '{default: 0};
    exp_dac = '{default: 0};
    @(posedge mclk);
    #1 chk_all();
    chk("irq", 0, servo_irq_ff);
    results();
  end
endmodule
`default_nettype wire
